// ---- hw/accs_top.sv ----
// Calibration coefficient store: offset and gain registers, error flag and sample correction.
// How it works
// - Two 24-bit coefficients are held, one for offset and one for gain.
// - Software reads and writes both coefficients through byte-wide registers.
// - The offset is signed two's complement, split high, middle and low with the high byte on top.
// - The offset moves the zero point of the conversion transfer function.
// - An offset calibration ending at the most positive or most negative value raises the error.
// - Offset bits weigh whole output LSBs on the 24-bit variant and down to 2^-8 on the 16-bit one.
// - The gain is unsigned fixed point, split over high, middle and low byte registers.
// - Gain bit 23 weighs one and each lower bit half the one above, down to 2^-23.
// - The gain sets the slope of the transfer function over 0 to 2 - 2^-23.
// - A gain calibration ending at all zeros or all ones raises the error.
// - Each sample has the offset subtracted and is then multiplied by the gain.
// - A finished calibration writes its result into the matching coefficient.
// - The converter error flag sets when a calibration result hits a coefficient limit.
`timescale 1ns/1ps
`default_nettype none
module accs_top #(
   parameter int unsigned SAMPLE_W = 24
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Special-function register port.
   input wire logic [2:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_ff,
   // Calibration engine results.
   input wire logic cal_done,
   input wire logic cal_is_gain,
   input wire logic [23:0] cal_value,
   // Error flag.
   input wire logic err_clear,
   output logic converter_error_flag_ff,
   // Conversion datapath.
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample_in,
   output logic corr_valid_ff,
   output logic [SAMPLE_W-1:0] corr_sample_ff
);
   logic [23:0] offset_coef_ff;
   logic [23:0] gain_coef_ff;
   logic [7:0] nxt_rdata;
   logic cal_err;

   accs_coef_if coef_bus ();

   assign coef_bus.offset_coef = offset_coef_ff;
   assign coef_bus.gain_coef = gain_coef_ff;

   // Replaces one byte lane of a coefficient word.
   function automatic logic [23:0] put_byte(input logic [23:0] word, input logic [7:0] b,
                                            input int unsigned lsb);
      logic [23:0] mask;
      mask = 24'hff << lsb;
      put_byte = (word & ~mask) | ((24'(b) << lsb) & mask);
   endfunction

   // Offset coefficient; a calibration result outranks a software write in the same cycle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         offset_coef_ff <= accs_pkg::OFFSET_COEF_RESET;
      end else if (cal_done && !cal_is_gain) begin
         offset_coef_ff <= cal_value;
      end else if (sfr_wr) begin
         unique case (sfr_addr)
            accs_pkg::OFFSET_COEF_HIGH_IDX:
               offset_coef_ff <= put_byte(offset_coef_ff, sfr_wdata, accs_pkg::HIGH_BYTE_LSB);
            accs_pkg::OFFSET_COEF_MID_IDX:
               offset_coef_ff <= put_byte(offset_coef_ff, sfr_wdata, accs_pkg::MID_BYTE_LSB);
            accs_pkg::OFFSET_COEF_LOW_IDX:
               offset_coef_ff <= put_byte(offset_coef_ff, sfr_wdata, accs_pkg::LOW_BYTE_LSB);
            default: begin
            end
         endcase
      end
   end

   // Gain coefficient.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gain_coef_ff <= accs_pkg::GAIN_COEF_RESET;
      end else if (cal_done && cal_is_gain) begin
         gain_coef_ff <= cal_value;
      end else if (sfr_wr) begin
         unique case (sfr_addr)
            accs_pkg::GAIN_COEF_HIGH_IDX:
               gain_coef_ff <= put_byte(gain_coef_ff, sfr_wdata, accs_pkg::HIGH_BYTE_LSB);
            accs_pkg::GAIN_COEF_MID_IDX:
               gain_coef_ff <= put_byte(gain_coef_ff, sfr_wdata, accs_pkg::MID_BYTE_LSB);
            accs_pkg::GAIN_COEF_LOW_IDX:
               gain_coef_ff <= put_byte(gain_coef_ff, sfr_wdata, accs_pkg::LOW_BYTE_LSB);
            default: begin
            end
         endcase
      end
   end

   // Only calibration results are checked; software may load any value it likes.
   always_comb begin
      if (!cal_done) begin
         cal_err = 1'b0;
      end else if (cal_is_gain) begin
         cal_err = cal_value == accs_pkg::GAIN_ZERO || cal_value == accs_pkg::GAIN_FULL;
      end else begin
         cal_err = cal_value == accs_pkg::OFFSET_MAX || cal_value == accs_pkg::OFFSET_MIN;
      end
   end

   // Sticky error; a new error in the clearing cycle wins so it is never lost.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         converter_error_flag_ff <= 1'b0;
      end else if (cal_err) begin
         converter_error_flag_ff <= 1'b1;
      end else if (err_clear) begin
         converter_error_flag_ff <= 1'b0;
      end
   end

   always_comb begin
      unique case (sfr_addr)
         accs_pkg::OFFSET_COEF_HIGH_IDX: nxt_rdata = offset_coef_ff[23:16];
         accs_pkg::OFFSET_COEF_MID_IDX: nxt_rdata = offset_coef_ff[15:8];
         accs_pkg::OFFSET_COEF_LOW_IDX: nxt_rdata = offset_coef_ff[7:0];
         accs_pkg::GAIN_COEF_HIGH_IDX: nxt_rdata = gain_coef_ff[23:16];
         accs_pkg::GAIN_COEF_MID_IDX: nxt_rdata = gain_coef_ff[15:8];
         accs_pkg::GAIN_COEF_LOW_IDX: nxt_rdata = gain_coef_ff[7:0];
         accs_pkg::CAL_STATUS_IDX: nxt_rdata = 8'(converter_error_flag_ff) << accs_pkg::STATUS_ERR_BIT;
         default: nxt_rdata = 8'h00;
      endcase
   end

   // Read data is registered and holds until the next read.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sfr_rdata_ff <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata_ff <= nxt_rdata;
      end
   end

   accs_correct #(
      .SAMPLE_W(SAMPLE_W)
   ) u_correct (
      .clk(clk),
      .reset(reset),
      .coef(coef_bus.corr),
      .sample_valid(sample_valid),
      .sample_in(sample_in),
      .corr_valid_ff(corr_valid_ff),
      .corr_sample_ff(corr_sample_ff)
   );

   a_cal_offset_store: assert property (@(posedge clk) disable iff (reset)
      cal_done && !cal_is_gain |=> offset_coef_ff == $past(cal_value))
      else $error("offset calibration result not stored");
   a_cal_gain_store: assert property (@(posedge clk) disable iff (reset)
      cal_done && cal_is_gain |=> gain_coef_ff == $past(cal_value))
      else $error("gain calibration result not stored");
   a_offset_limit_err: assert property (@(posedge clk) disable iff (reset)
      cal_done && !cal_is_gain && (cal_value == 24'h7fffff || cal_value == 24'h800000)
      |=> converter_error_flag_ff) else $error("offset limit did not raise error");
   a_gain_limit_err: assert property (@(posedge clk) disable iff (reset)
      cal_done && cal_is_gain && (cal_value == 24'h000000 || cal_value == 24'hffffff)
      |=> converter_error_flag_ff) else $error("gain limit did not raise error");
   a_err_no_false: assert property (@(posedge clk) disable iff (reset)
      !converter_error_flag_ff && !cal_done |=> !converter_error_flag_ff)
      else $error("error flag rose without a calibration");
   a_err_clear: assert property (@(posedge clk) disable iff (reset)
      err_clear && !cal_done |=> !converter_error_flag_ff)
      else $error("error flag did not clear");
   a_sw_offset_high: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && !cal_done && sfr_addr == 3'h0
      |=> offset_coef_ff[23:16] == $past(sfr_wdata) && offset_coef_ff[15:0] == $past(offset_coef_ff[15:0]))
      else $error("offset high byte write wrong");
   a_sw_gain_low: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && !cal_done && sfr_addr == 3'h5 |=> gain_coef_ff[7:0] == $past(sfr_wdata))
      else $error("gain low byte write wrong");
   a_read_gain_mid: assert property (@(posedge clk) disable iff (reset)
      sfr_rd && sfr_addr == 3'h4 |=> sfr_rdata_ff == $past(gain_coef_ff[15:8]))
      else $error("gain middle byte read wrong");
   c_offset_cal: cover property (@(posedge clk) disable iff (reset) cal_done && !cal_is_gain);
   c_gain_err: cover property (@(posedge clk) disable iff (reset)
      cal_done && cal_is_gain ##1 converter_error_flag_ff);
   c_sw_then_sample: cover property (@(posedge clk) disable iff (reset)
      sfr_wr ##2 sample_valid ##1 corr_valid_ff);
endmodule
`default_nettype wire

// ---- hw/accs_pkg.sv ----
// Constants shared by the calibration coefficient store and its correction datapath.
package accs_pkg;
   localparam int unsigned COEF_W = 24;
   localparam int unsigned SFR_AW = 3;
   // Register indices on the byte-wide special-function register port.
   localparam logic [2:0] OFFSET_COEF_HIGH_IDX = 3'h0;
   localparam logic [2:0] OFFSET_COEF_MID_IDX = 3'h1;
   localparam logic [2:0] OFFSET_COEF_LOW_IDX = 3'h2;
   localparam logic [2:0] GAIN_COEF_HIGH_IDX = 3'h3;
   localparam logic [2:0] GAIN_COEF_MID_IDX = 3'h4;
   localparam logic [2:0] GAIN_COEF_LOW_IDX = 3'h5;
   localparam logic [2:0] CAL_STATUS_IDX = 3'h6;
   // Field positions within the coefficient words and the status byte.
   localparam int unsigned HIGH_BYTE_LSB = 16;
   localparam int unsigned MID_BYTE_LSB = 8;
   localparam int unsigned LOW_BYTE_LSB = 0;
   localparam int unsigned STATUS_ERR_BIT = 0;
   // Gain bit 23 weighs one, so products are scaled down by this many bits.
   localparam int unsigned GAIN_FRAC_BITS = 23;
   // Reset values: zero offset and unity gain.
   localparam logic [23:0] OFFSET_COEF_RESET = 24'h000000;
   localparam logic [23:0] GAIN_COEF_RESET = 24'h800000;
   // Range limits that make a calibration result an error.
   localparam logic [23:0] OFFSET_MAX = 24'h7fffff;
   localparam logic [23:0] OFFSET_MIN = 24'h800000;
   localparam logic [23:0] GAIN_ZERO = 24'h000000;
   localparam logic [23:0] GAIN_FULL = 24'hffffff;
endpackage

// ---- hw/accs_coef_if.sv ----
// Carrier of the stored coefficients from the register bank to the correction datapath.
`timescale 1ns/1ps
`default_nettype none
interface accs_coef_if;
   logic [23:0] offset_coef;
   logic [23:0] gain_coef;
   modport store (output offset_coef, output gain_coef);
   modport corr (input offset_coef, input gain_coef);
endinterface
`default_nettype wire

// ---- hw/accs_correct.sv ----
// Offset-and-gain correction of converter samples using the stored coefficients.
`timescale 1ns/1ps
`default_nettype none
module accs_correct #(
   parameter int unsigned SAMPLE_W = 24
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Coefficients.
   accs_coef_if.corr coef,
   // Raw sample in.
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample_in,
   // Corrected sample out.
   output logic corr_valid_ff,
   output logic [SAMPLE_W-1:0] corr_sample_ff
);
   localparam int unsigned ALIGN = 24 - SAMPLE_W;

   logic [23:0] aligned;
   logic signed [24:0] diff;
   logic signed [49:0] prod;
   logic [23:0] nxt_corr;

   // A narrow sample sits at the top of the word, so offset low bits act as fractions.
   assign aligned = 24'(sample_in) << ALIGN;

   always_comb begin
      diff = $signed({aligned[23], aligned}) - $signed({coef.offset_coef[23], coef.offset_coef});
      prod = 50'(diff) * 50'($signed({1'b0, coef.gain_coef}));
      // Clip rather than wrap, so a large gain never flips the sign of a result.
      if (prod[49:46] == 4'h0 || prod[49:46] == 4'hf) begin
         nxt_corr = prod[46:23];
      end else if (prod[49]) begin
         nxt_corr = accs_pkg::OFFSET_MIN;
      end else begin
         nxt_corr = accs_pkg::OFFSET_MAX;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         corr_valid_ff <= 1'b0;
         corr_sample_ff <= '0;
      end else begin
         corr_valid_ff <= sample_valid;
         if (sample_valid) begin
            corr_sample_ff <= nxt_corr[23 -: SAMPLE_W];
         end
      end
   end

   a_corr_latency: assert property (@(posedge clk) disable iff (reset)
      sample_valid |=> corr_valid_ff) else $error("corrected sample not valid one cycle later");
   a_unity_passes: assert property (@(posedge clk) disable iff (reset)
      sample_valid && coef.offset_coef == 24'h000000 && coef.gain_coef == 24'h800000
      |=> corr_sample_ff == $past(sample_in)) else $error("unity correction altered sample");
   a_offset_zero: assert property (@(posedge clk) disable iff (reset)
      sample_valid && aligned == coef.offset_coef |=> corr_sample_ff == '0)
      else $error("sample equal to offset did not map to zero");
   c_corr_sample: cover property (@(posedge clk) disable iff (reset)
      sample_valid && coef.gain_coef != 24'h800000);
endmodule
`default_nettype wire

// ---- test/accs_top_tb.sv ----
// Self-checking testbench for the calibration coefficient store.
`timescale 1ns/1ps
`default_nettype none
module accs_top_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] sfr_addr = 3'h0;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic cal_done = 1'b0;
   logic cal_is_gain = 1'b0;
   logic [23:0] cal_value = 24'h000000;
   logic err_clear = 1'b0;
   logic sample_valid = 1'b0;
   logic [23:0] sample_in = 24'h000000;
   wire logic [7:0] sfr_rdata_ff;
   wire logic converter_error_flag_ff;
   wire logic corr_valid_ff;
   wire logic [23:0] corr_sample_ff;
   int miscompares = 0;
   int n_compared = 0;
   logic [7:0] rd;
   always #20 clk = ~clk;
   accs_top #(.SAMPLE_W(24)) u_dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff),
      .cal_done(cal_done), .cal_is_gain(cal_is_gain), .cal_value(cal_value),
      .err_clear(err_clear), .converter_error_flag_ff(converter_error_flag_ff),
      .sample_valid(sample_valid), .sample_in(sample_in), .corr_valid_ff(corr_valid_ff),
      .corr_sample_ff(corr_sample_ff));
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic chk_flag(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %b seen %b", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Bus tasks change signals at the falling edge, so the rising edge sees them settled.
   task automatic sfr_write(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task automatic sfr_read(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      d = sfr_rdata_ff;
   endtask
   task automatic set_coefs(input logic [23:0] off, input logic [23:0] gain);
      for (int i = 0; i < 3; i++) sfr_write(3'(i), off[23-8*i -: 8]);
      for (int i = 0; i < 3; i++) sfr_write(3'(i + 3), gain[23-8*i -: 8]);
   endtask
   task automatic test_reset();
      logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
      chk_flag("flag after reset", 1'b0, converter_error_flag_ff);
      for (int i = 0; i < 8; i++) begin
         sfr_read(3'(i), rd);
         chk_byte("reset byte", exp[i], rd);
      end
      $display("test reset done");
   endtask
   task automatic test_rw();
      logic [7:0] pat [6] = '{8'ha5, 8'h3c, 8'h81, 8'h94, 8'h00, 8'h01};
      for (int i = 0; i < 6; i++) sfr_write(3'(i), pat[i]);
      sfr_write(3'h6, 8'hff);
      for (int i = 0; i < 6; i++) begin
         sfr_read(3'(i), rd);
         chk_byte("coef byte", pat[i], rd);
      end
      sfr_read(3'h6, rd);
      chk_byte("status after write", 8'h00, rd);
      $display("test rw done");
   endtask
   task automatic test_corr();
      logic [23:0] tab [7][4] = '{'{24'h000000, 24'h400000, 24'h000010, 24'h000008},
         '{24'h000004, 24'h940000, 24'h000014, 24'h000012},
         '{24'h800000, 24'h800000, 24'h7fffff, 24'h7fffff},
         '{24'h000010, 24'h800000, 24'h000000, 24'hfffff0},
         '{24'h000004, 24'h940000, 24'h000004, 24'h000000},
         '{24'h000000, 24'h800000, 24'h123456, 24'h123456},
         '{24'h7fffff, 24'h800000, 24'h800000, 24'h800000}};
      for (int i = 0; i < 7; i++) begin
         set_coefs(tab[i][0], tab[i][1]);
         @(negedge clk);
         sample_in = tab[i][2];
         sample_valid = 1'b1;
         @(negedge clk);
         sample_valid = 1'b0;
         chk_flag("corr valid", 1'b1, corr_valid_ff);
         chk_word("corr sample", tab[i][3], corr_sample_ff);
         @(negedge clk);
         chk_flag("corr valid drop", 1'b0, corr_valid_ff);
      end
      chk_flag("flag after sw writes", 1'b0, converter_error_flag_ff);
      $display("test corr done");
   endtask
   task automatic cal_pulse(input logic g, input logic [23:0] v, input logic clr);
      @(negedge clk);
      cal_is_gain = g;
      cal_value = v;
      cal_done = 1'b1;
      err_clear = clr;
      @(negedge clk);
      cal_done = 1'b0;
      err_clear = 1'b0;
   endtask
   task automatic test_cal();
      logic [24:0] tab [6] = '{{1'b0, 24'h7fffff}, {1'b0, 24'h800000}, {1'b1, 24'h000000},
         {1'b1, 24'hffffff}, {1'b0, 24'h123456}, {1'b1, 24'h940000}};
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         err_clear = 1'b1;
         @(negedge clk);
         err_clear = 1'b0;
         chk_flag("flag cleared", 1'b0, converter_error_flag_ff);
         cal_pulse(tab[i][24], tab[i][23:0], 1'b0);
         chk_flag("cal flag", i < 4, converter_error_flag_ff);
         for (int b = 0; b < 3; b++) begin
            sfr_read(3'(b + 3 * tab[i][24]), rd);
            chk_byte("cal result byte", tab[i][23-8*b -: 8], rd);
         end
         sfr_read(3'h6, rd);
         chk_byte("status byte", {7'h00, i < 4}, rd);
      end
      // Set wins over a clear in the same cycle.
      cal_pulse(1'b1, 24'hffffff, 1'b1);
      chk_flag("set over clear", 1'b1, converter_error_flag_ff);
      $display("test cal done");
   endtask
   initial begin
      repeat (3) @(negedge clk);
      reset = 1'b0;
      test_reset();
      test_rw();
      test_corr();
      test_cal();
      report_and_stop();
   end
   // About 230 cycles are expected; the limit leaves a wide margin.
   initial begin
      #(40 * 5000);
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
